// >>> ckm_keygen.sv
// Shared constants and the phase accumulator used by the keying modulator
`default_nettype none

package ckm_pkg;
    localparam int ACC_W = 32;
    localparam int MOD_W = 16;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY_INC = 8'h04;
    localparam logic [7:0] OFS_CAR_FREQ = 8'h08;
    localparam logic [7:0] OFS_HOP_FREQ = 8'h0C;
    localparam logic [7:0] OFS_PERIOD = 8'h10;
    localparam logic [7:0] OFS_WIDTH = 8'h14;
    localparam logic [7:0] OFS_DEVIATION = 8'h18;
    localparam logic [7:0] OFS_MOD_INC = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TYPE_LSB = 1;
    localparam int CTRL_SRC_LSB = 3;
    localparam int CTRL_SHAPE_LSB = 5;
    localparam int CTRL_INV_BIT = 7;
    localparam int CTRL_PULSE_BIT = 8;
    localparam int CTRL_W = 9;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
    localparam logic [31:0] INC_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0064;
    localparam logic [31:0] WIDTH_RESET = 32'h0000_0032;

    typedef enum logic [1:0] {MT_PWM, MT_ASK, MT_FSK, MT_PSK} ckm_type_e;
    typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_CHAN} ckm_src_e;
    typedef enum logic [1:0] {SH_SQUARE, SH_RAMP, SH_TRIANGLE} ckm_shape_e;
endpackage : ckm_pkg

module ckm_keygen #(
    parameter int ACC_W = ckm_pkg::ACC_W
) (
    input wire logic clk,                  // Sample clock
    input wire logic resetn,               // Asynchronous reset, active low
    input wire logic [ACC_W-1:0] inc,      // Phase increment per cycle
    output logic [ACC_W-1:0] phase         // Accumulated phase
);
    import ckm_pkg::*;

    generate
        if (ACC_W < 2) begin : g_bad_width
            $error("ckm_keygen: ACC_W too small");
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= '0;
        end else begin
            phase <= phase + inc;
        end
    end
endmodule : ckm_keygen

`default_nettype wire

// >>> ckm_modulator.sv
// Carrier keying and pulse width modulation control for one channel
`default_nettype none

// Functional notes
// - PWM only allowed on pulse carrier
// - Modulating amplitude sets high pulse width
// - Full-scale modulation gives the programmed deviation
// - Deviation programmed; external full span maps to it
// - ASK: carrier on for one, off otherwise
// - FSK: hop frequency on one, carrier on zero
// - PSK rise 0 deg, fall 180; inverted swaps
// - Channel source must be enabled to modulate
// - Source channel waveform feeds modulator internally
// - Internal source rate and shape programmable
module ckm_modulator #(
    parameter int ACC_W = ckm_pkg::ACC_W,
    parameter int MOD_W = ckm_pkg::MOD_W
) (
    input wire logic clk,                       // Sample clock
    input wire logic resetn,                    // Async reset, active low
    input wire logic [7:0] regAddr,             // Register byte address
    input wire logic [31:0] regWrData,          // Register write data
    input wire logic regWrite,                  // Write strobe
    input wire logic regRead,                   // Read strobe
    output logic [31:0] regRdData,              // Read data, next cycle
    input wire logic extTrig,                   // External trigger level
    input wire logic signed [MOD_W-1:0] extMod, // External modulation
    input wire logic signed [MOD_W-1:0] chanMod, // Other channel waveform
    input wire logic srcChanEn,                 // Source channel enabled
    output logic [ACC_W-1:0] freqWord,          // Carrier frequency word
    output logic phaseFlip,                     // High adds 180 degrees
    output logic ampEnable,                     // Carrier amplitude on
    output logic pulseOut,                      // Pulse carrier output
    output logic [31:0] pulseWidth              // Width of current pulse
);
    import ckm_pkg::*;

    generate
        if (MOD_W < 2 || MOD_W > 31 || ACC_W < MOD_W || ACC_W > 32) begin
            : g_bad_params
            $error("ckm_modulator: unsupported ACC_W or MOD_W");
        end
    endgenerate

    localparam logic signed [MOD_W-1:0] MOD_MAX = {1'b0, {(MOD_W-1){1'b1}}};
    localparam logic signed [MOD_W-1:0] MOD_MIN =
        {1'b1, {(MOD_W-2){1'b0}}, 1'b1};
    logic [CTRL_W-1:0] ctrl_reg;
    logic [ACC_W-1:0] keyInc_reg;
    logic [ACC_W-1:0] carFreq_reg;
    logic [ACC_W-1:0] hopFreq_reg;
    logic [31:0] period_reg;
    logic [31:0] widthBase_reg;
    logic [31:0] deviation_reg;
    logic [ACC_W-1:0] modInc_reg;

    logic modEnable;
    ckm_type_e modType;
    ckm_src_e modSrc;
    ckm_shape_e modShape;
    logic pskInvert;
    logic carrierPulse;
    assign modEnable = ctrl_reg[CTRL_EN_BIT];
    assign modType = ckm_type_e'(ctrl_reg[CTRL_TYPE_LSB +: 2]);
    assign modSrc = ckm_src_e'(ctrl_reg[CTRL_SRC_LSB +: 2]);
    assign modShape = ckm_shape_e'(ctrl_reg[CTRL_SHAPE_LSB +: 2]);
    assign pskInvert = ctrl_reg[CTRL_INV_BIT];
    assign carrierPulse = ctrl_reg[CTRL_PULSE_BIT];

    // Register writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
            keyInc_reg <= INC_RESET[ACC_W-1:0];
            carFreq_reg <= INC_RESET[ACC_W-1:0];
            hopFreq_reg <= INC_RESET[ACC_W-1:0];
            period_reg <= PERIOD_RESET;
            widthBase_reg <= WIDTH_RESET;
            deviation_reg <= INC_RESET;
            modInc_reg <= INC_RESET[ACC_W-1:0];
        end else if (regWrite) begin
            if (regAddr == OFS_CTRL) begin
                ctrl_reg <= regWrData[CTRL_W-1:0];
            end else if (regAddr == OFS_KEY_INC) begin
                keyInc_reg <= regWrData[ACC_W-1:0];
            end else if (regAddr == OFS_CAR_FREQ) begin
                carFreq_reg <= regWrData[ACC_W-1:0];
            end else if (regAddr == OFS_HOP_FREQ) begin
                hopFreq_reg <= regWrData[ACC_W-1:0];
            end else if (regAddr == OFS_PERIOD) begin
                period_reg <= regWrData;
            end else if (regAddr == OFS_WIDTH) begin
                widthBase_reg <= regWrData;
            end else if (regAddr == OFS_DEVIATION) begin
                deviation_reg <= regWrData;
            end else if (regAddr == OFS_MOD_INC) begin
                modInc_reg <= regWrData[ACC_W-1:0];
            end
        end
    end

    // Internal generators: keying clock at twice the programmed rate
    logic [ACC_W-1:0] keyPhase;
    logic [ACC_W-1:0] modPhase;
    ckm_keygen #(.ACC_W(ACC_W)) u_keyGen (
        .clk(clk),
        .resetn(resetn),
        .inc({keyInc_reg[ACC_W-2:0], 1'b0}),
        .phase(keyPhase)
    );

    ckm_keygen #(.ACC_W(ACC_W)) u_modGen (
        .clk(clk),
        .resetn(resetn),
        .inc(modInc_reg),
        .phase(modPhase)
    );

    function automatic logic signed [MOD_W-1:0] shapeSample(
        input ckm_shape_e shape,
        input logic [ACC_W-1:0] ph
    );
        logic [MOD_W-1:0] top;
        logic [MOD_W-1:0] fold;
        top = ph[ACC_W-1 -: MOD_W];
        fold = top[MOD_W-1] ? ~{top[MOD_W-2:0], 1'b0} : {top[MOD_W-2:0], 1'b0};
        case (shape)
            SH_SQUARE: shapeSample = top[MOD_W-1] ? MOD_MIN : MOD_MAX;
            SH_RAMP: shapeSample = {~top[MOD_W-1], top[MOD_W-2:0]};
            default: shapeSample = {~fold[MOD_W-1], fold[MOD_W-2:0]};
        endcase
    endfunction : shapeSample

    // Source selection: the other channel arrives on an internal port
    logic keyRaw;
    logic signed [MOD_W-1:0] modSample;
    always_comb begin
        case (modSrc)
            SRC_INT: begin
                keyRaw = keyPhase[ACC_W-1];
                modSample = shapeSample(modShape, modPhase);
            end
            SRC_EXT: begin
                keyRaw = extTrig;
                modSample = extMod;
            end
            default: begin
                keyRaw = ~chanMod[MOD_W-1];
                modSample = chanMod;
            end
        endcase
    end

    logic chanBlocked;
    logic pwmRefused;
    logic modActive;
    assign chanBlocked = modSrc == SRC_CHAN && !srcChanEn;
    assign pwmRefused = modEnable && modType == MT_PWM && !carrierPulse;
    assign modActive = modEnable && !chanBlocked && !pwmRefused;
    logic activeAsk;
    logic activeFsk;
    logic activePsk;
    logic activePwm;
    assign activeAsk = modActive && modType == MT_ASK;
    assign activeFsk = modActive && modType == MT_FSK;
    assign activePsk = modActive && modType == MT_PSK;
    assign activePwm = modActive && modType == MT_PWM;

    // Keying bit is registered so every change lands on a clock edge
    logic keyBit_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            keyBit_reg <= 1'b0;
        end else begin
            keyBit_reg <= keyRaw;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ampEnable <= 1'b1;
        end else begin
            ampEnable <= !activeAsk || keyBit_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            freqWord <= '0;
        end else begin
            freqWord <= (activeFsk && keyBit_reg) ? hopFreq_reg
                                                  : carFreq_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phaseFlip <= 1'b0;
        end else begin
            phaseFlip <= activePsk && (keyBit_reg == pskInvert);
        end
    end

    // Pulse width: base plus deviation scaled by the modulating sample
    logic signed [32+MOD_W:0] devProd;
    logic signed [33:0] widthCalc;
    logic [31:0] widthTarget;
    assign devProd = $signed({1'b0, deviation_reg}) * modSample;
    assign widthCalc = $signed({2'b00, widthBase_reg})
                     + 34'(devProd >>> (MOD_W - 1));
    always_comb begin
        if (!activePwm) begin
            widthTarget = widthBase_reg;
        end else if (widthCalc < 0) begin
            widthTarget = 32'h0000_0000;
        end else if (widthCalc > $signed({2'b00, period_reg})) begin
            widthTarget = period_reg;
        end else begin
            widthTarget = widthCalc[31:0];
        end
    end

    // Width is taken only at period start, so no pulse is cut short
    logic [31:0] pulseCnt_reg;
    logic cntLast;
    assign cntLast = {1'b0, pulseCnt_reg} + 33'h0_0000_0001
                   >= {1'b0, period_reg};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulseCnt_reg <= 32'h0000_0000;
        end else if (cntLast) begin
            pulseCnt_reg <= 32'h0000_0000;
        end else begin
            pulseCnt_reg <= pulseCnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulseWidth <= WIDTH_RESET;
        end else if (cntLast) begin
            pulseWidth <= widthTarget;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulseOut <= 1'b0;
        end else begin
            pulseOut <= pulseCnt_reg < pulseWidth;
        end
    end

    // Register reads, answered in the following cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 32'h0000_0000;
        end else if (regRead) begin
            if (regAddr == OFS_CTRL) begin
                regRdData <= 32'(ctrl_reg);
            end else if (regAddr == OFS_KEY_INC) begin
                regRdData <= 32'(keyInc_reg);
            end else if (regAddr == OFS_CAR_FREQ) begin
                regRdData <= 32'(carFreq_reg);
            end else if (regAddr == OFS_HOP_FREQ) begin
                regRdData <= 32'(hopFreq_reg);
            end else if (regAddr == OFS_PERIOD) begin
                regRdData <= period_reg;
            end else if (regAddr == OFS_WIDTH) begin
                regRdData <= widthBase_reg;
            end else if (regAddr == OFS_DEVIATION) begin
                regRdData <= deviation_reg;
            end else if (regAddr == OFS_MOD_INC) begin
                regRdData <= 32'(modInc_reg);
            end else if (regAddr == OFS_STATUS) begin
                regRdData <= {27'h000_0000, chanBlocked, pwmRefused,
                              modActive, pulseOut, keyBit_reg};
            end else begin
                regRdData <= 32'h0000_0000;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence seqKeyRise;
        (activePsk && !pskInvert && !keyBit_reg)
            ##1 (activePsk && !pskInvert && keyBit_reg);
    endsequence
    sequence seqKeyFall;
        (activePsk && !pskInvert && keyBit_reg)
            ##1 (activePsk && !pskInvert && !keyBit_reg);
    endsequence
    a_pwm_refused: assert property (
        pwmRefused && cntLast |=> pulseWidth == $past(widthBase_reg))
        else $error("PWM applied to non-pulse carrier");
    a_pulse_shape: assert property (
        $past(resetn) |-> pulseOut
            == ($past(pulseCnt_reg) < $past(pulseWidth)))
        else $error("Pulse output does not follow width");
    a_width_bound: assert property (
        activePwm && modSample == MOD_MAX && !widthCalc[33]
            && widthCalc <= $signed({2'b00, period_reg})
            |-> widthTarget + (deviation_reg >> (MOD_W - 1))
                >= widthBase_reg + deviation_reg - 32'h0000_0001)
        else $error("Full-scale sample misses deviation");
    a_ask_keying: assert property (
        activeAsk |=> ampEnable == $past(keyBit_reg))
        else $error("ASK amplitude does not follow key bit");
    a_ext_key: assert property (
        modSrc == SRC_EXT |=> keyBit_reg == $past(extTrig))
        else $error("External trigger level not keyed");
    a_fsk_freq: assert property (
        activeFsk |=> freqWord == ($past(keyBit_reg) ? $past(hopFreq_reg)
                                                    : $past(carFreq_reg)))
        else $error("FSK frequency word wrong");
    a_psk_rise: assert property (
        seqKeyRise |=> !phaseFlip)
        else $error("PSK rise did not give 0 degrees");
    a_psk_fall: assert property (
        seqKeyFall |=> phaseFlip)
        else $error("PSK fall did not give 180 degrees");
    a_chan_blocked: assert property (
        modEnable && chanBlocked |=> ampEnable && !phaseFlip
            && freqWord == $past(carFreq_reg))
        else $error("Disabled source channel still modulates");
    a_key_sync: assert property (
        activeAsk && $past(activeAsk) && $stable(keyBit_reg)
            |=> $stable(ampEnable))
        else $error("Amplitude changed without a keying edge");
endmodule : ckm_modulator

`default_nettype wire

// >>> ckm_ext_source.sv
// Model of the external trigger and modulation source feeding one channel
`default_nettype none

module ckm_ext_source (
    input wire logic clk, // Sample clock
    output logic extTrig, // Keying level
    output logic signed [ckm_pkg::MOD_W-1:0] extMod // Modulating sample
);
    timeunit 1ns;
    timeprecision 100ps;
    import ckm_pkg::*;

    initial begin
        extTrig = 1'b1;
        extMod = '0;
    end

    // Binary level held until the next change, applied on a clock edge
    task automatic setKey(input logic v);
        @(posedge clk);
        extTrig <= v;
    endtask : setKey

    // Sample spans the full signed range of the input
    task automatic setMod(input logic signed [MOD_W-1:0] s);
        @(posedge clk);
        extMod <= s;
    endtask : setMod
endmodule : ckm_ext_source

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the carrier keying and PWM modulator
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ckm_pkg::*;

    localparam logic [31:0] CAR = 32'h1111_0000;
    localparam logic [31:0] HOP = 32'h2222_0000;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdData;
    logic extTrig;
    logic signed [MOD_W-1:0] extMod;
    logic signed [MOD_W-1:0] chanMod = 16'h0000;
    logic srcChanEn = 1'b0;
    logic [ACC_W-1:0] freqWord;
    logic phaseFlip;
    logic ampEnable;
    logic pulseOut;
    logic [31:0] pulseWidth;
    int bad_count = 0;
    int checked = 0;
    int n;

    always #2.5 clk = ~clk;

    ckm_modulator ckm_modulator_i (
        .clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .extTrig(extTrig), .extMod(extMod),
        .chanMod(chanMod), .srcChanEn(srcChanEn), .freqWord(freqWord),
        .phaseFlip(phaseFlip), .ampEnable(ampEnable), .pulseOut(pulseOut),
        .pulseWidth(pulseWidth)
    );

    ckm_ext_source partner_i (.clk(clk), .extTrig(extTrig), .extMod(extMod));

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chkWord

    task automatic chkBit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chkBit

    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask : regWr

    task automatic regChk(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chkWord(regRdData, exp);
        @(posedge clk);
    endtask : regChk

    task automatic setMode(input logic [31:0] c);
        regWr(OFS_CTRL, c);
        repeat (3) @(posedge clk);
    endtask : setMode

    // Key change must show two edges later and not one edge early
    task automatic keyChk(input logic v, input logic [31:0] eF,
                          input logic eA, input logic eP);
        logic [31:0] oF;
        logic oA;
        logic oP;
        #1;
        oF = freqWord;
        oA = ampEnable;
        oP = phaseFlip;
        partner_i.setKey(v);
        @(posedge clk);
        #1;
        chkWord(freqWord, oF);
        chkBit(ampEnable, oA);
        chkBit(phaseFlip, oP);
        @(posedge clk);
        #1;
        chkWord(freqWord, eF);
        chkBit(ampEnable, eA);
        chkBit(phaseFlip, eP);
        @(posedge clk);
    endtask : keyChk

    task automatic waitChk(input int c, input logic e);
        repeat (c) @(posedge clk);
        #1;
        chkBit(ampEnable, e);
        @(posedge clk);
    endtask : waitChk

    task automatic waitAmp(input logic v, input int lim);
        while (ampEnable !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : waitAmp

    task automatic results();
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        regChk(OFS_CTRL, 32'h0000_0000);
        regChk(OFS_PERIOD, 32'h0000_0064);
        regChk(OFS_WIDTH, 32'h0000_0032);
        regChk(8'h24, 32'h0000_0000);
        regWr(OFS_CAR_FREQ, CAR);
        regWr(OFS_HOP_FREQ, HOP);
        regWr(OFS_DEVIATION, 32'h0000_0020);
        // Amplitude, frequency and phase keying from the trigger input
        setMode(32'h0000_000B);
        keyChk(1'b1, CAR, 1'b1, 1'b0);
        keyChk(1'b0, CAR, 1'b0, 1'b0);
        keyChk(1'b1, CAR, 1'b1, 1'b0);
        setMode(32'h0000_000D);
        keyChk(1'b0, CAR, 1'b1, 1'b0);
        keyChk(1'b1, HOP, 1'b1, 1'b0);
        keyChk(1'b0, CAR, 1'b1, 1'b0);
        setMode(32'h0000_000F);
        keyChk(1'b1, CAR, 1'b1, 1'b0);
        keyChk(1'b0, CAR, 1'b1, 1'b1);
        setMode(32'h0000_008F);
        regChk(OFS_CTRL, 32'h0000_008F);
        keyChk(1'b1, CAR, 1'b1, 1'b1);
        keyChk(1'b0, CAR, 1'b1, 1'b0);
        // Channel source keys only while that channel is enabled
        chanMod <= -16'sd100;
        setMode(32'h0000_0013);
        waitChk(3, 1'b1);
        srcChanEn <= 1'b1;
        waitChk(3, 1'b0);
        chanMod <= 16'sd100;
        waitChk(3, 1'b1);
        // Internal keying: step 2*0x0100_0000 gives a 128-cycle period
        regWr(OFS_KEY_INC, 32'h0100_0000);
        setMode(32'h0000_0003);
        n = 0;
        waitAmp(1'b0, 300);
        waitAmp(1'b1, 600);
        n = 0;
        waitAmp(1'b0, 300);
        waitAmp(1'b1, 300);
        chkWord(32'(n), 32'd128);
        @(posedge clk);
        // PWM refused on a non-pulse carrier, then applied on a pulse
        partner_i.setMod(16'sh8000);
        setMode(32'h0000_0009);
        repeat (250) @(posedge clk);
        #1;
        chkWord(pulseWidth, 32'h0000_0032);
        @(posedge clk);
        setMode(32'h0000_0109);
        repeat (250) @(posedge clk);
        #1;
        chkWord(pulseWidth, 32'd18);
        n = 0;
        repeat (100) begin
            @(posedge clk);
            #1;
            if (pulseOut === 1'b1) n++;
        end
        chkWord(32'(n), 32'd18);
        @(posedge clk);
        partner_i.setMod(16'sh7FFF);
        repeat (250) @(posedge clk);
        #1;
        chkWord(pulseWidth, 32'd81);
        // Internal modulator rests at phase zero: shape picks the sample
        @(posedge clk);
        setMode(32'h0000_0121);
        repeat (250) @(posedge clk);
        #1;
        chkWord(pulseWidth, 32'd18);
        @(posedge clk);
        setMode(32'h0000_0101);
        repeat (250) @(posedge clk);
        #1;
        chkWord(pulseWidth, 32'd81);
        results();
    end
endmodule : testbench

`default_nettype wire
